// >>> design/asc_control.sv
// Purpose: Register side and sequencing of a 10-bit sampling converter
// Assumes: Trigger flags and core result come from SYS_CLK logic
// Notes:   Converter core result is sampled on the last converter cycle

`timescale 1ns/1ps

module asc_control #(
    parameter int NUM_TRIG = 8
) (
    input  wire logic                SYS_CLK,
    input  wire logic                RSTN,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR_STB,
    input  wire logic                RD_STB,
    output logic      [7:0]          RDATA,
    input  wire logic                GLOBAL_IRQ_EN,
    input  wire logic                IRQ_ACK,
    output logic                     IRQ,
    input  wire logic [2:0]          TRIG_SRC_SEL,
    input  wire logic [NUM_TRIG-1:0] TRIG_FLAGS,
    input  wire logic [9:0]          CORE_RESULT,
    output logic                     CONVERTER_ON,
    output logic                     CONV_BUSY,
    output logic                     ADC_CLK_TICK,
    output logic      [3:0]          CHANNEL_SEL,
    output logic      [1:0]          REF_SEL,
    output logic                     TEMP_SENSOR_ON
);

    // ****************************************
    // State
    // ****************************************
    asc_pkg::asc_state_t state_reg;
    asc_pkg::asc_state_t state_next;

    logic       converter_on_reg;
    logic       auto_trigger_on_reg;
    logic       completion_flag_reg;
    logic       completion_irq_enable_reg;
    logic [2:0] clock_divider_select_reg;
    logic [1:0] reference_select_reg;
    logic       left_justify_reg;
    logic [3:0] channel_select_reg;
    logic [9:0] conversion_result_reg;
    logic       read_lock_reg;
    logic       init_pending_reg;
    logic       long_conv_reg;
    logic [4:0] tick_count_reg;
    logic [3:0] active_channel_reg;
    logic [1:0] active_ref_reg;
    logic       trig_prev_reg;
    logic [7:0] rdata_reg;

    // ****************************************
    // Register decode
    // ****************************************
    logic wr_ctrl;
    logic wr_input;
    logic rd_low;
    logic rd_high;
    logic rd_ctrl;
    logic rd_input;

    assign wr_ctrl  = WR_STB && (ADDR == asc_pkg::CTRL_STATUS_OFF);
    assign wr_input = WR_STB && (ADDR == asc_pkg::INPUT_REF_OFF);
    assign rd_low   = RD_STB && (ADDR == asc_pkg::RESULT_LOW_OFF);
    assign rd_high  = RD_STB && (ADDR == asc_pkg::RESULT_HIGH_OFF);
    assign rd_ctrl  = RD_STB && (ADDR == asc_pkg::CTRL_STATUS_OFF);
    assign rd_input = RD_STB && (ADDR == asc_pkg::INPUT_REF_OFF);

    // ****************************************
    // Sequencing
    // ****************************************
    logic       converter_on_next;
    logic       enable_rise;
    logic       wr_start;
    logic       trig_level;
    logic       trig_edge;
    logic       free_run;
    logic       launch;
    logic       cold_launch;
    logic       done;
    logic       conv_tick;
    logic [4:0] conv_len;
    logic       busy;

    assign busy              = (state_reg == asc_pkg::ASC_CONV);
    assign converter_on_next = wr_ctrl ? WDATA[asc_pkg::CONVERTER_ON_BIT] : converter_on_reg;
    assign enable_rise       = converter_on_next && !converter_on_reg;
    assign wr_start          = wr_ctrl && WDATA[asc_pkg::START_BIT];
    assign free_run          = auto_trigger_on_reg && (TRIG_SRC_SEL == asc_pkg::TRIG_FREE_RUN);
    // Free running selects no flag, so the switch itself makes no edge
    assign trig_level        = auto_trigger_on_reg && (TRIG_SRC_SEL != asc_pkg::TRIG_FREE_RUN)
                               && TRIG_FLAGS[TRIG_SRC_SEL];
    assign trig_edge         = trig_level && !trig_prev_reg;
    assign conv_len          = long_conv_reg ? asc_pkg::FIRST_CONV_CYCLES
                                             : asc_pkg::NORM_CONV_CYCLES;
    assign done              = busy && converter_on_next && conv_tick
                               && (tick_count_reg == conv_len - 5'h01);
    // Relaunch on completion rides on the last tick, so no prescaler restart
    assign cold_launch       = converter_on_next && !busy
                               && (wr_start || trig_edge);
    assign launch            = cold_launch || (done && free_run);

    always_comb begin
        state_next = state_reg;
        if (!converter_on_next) begin
            state_next = asc_pkg::ASC_IDLE;
        end else if (launch) begin
            state_next = asc_pkg::ASC_CONV;
        end else if (done) begin
            state_next = asc_pkg::ASC_IDLE;
        end
    end

    asc_prescaler u_prescaler (
        .clk         (SYS_CLK),
        .rst_n       (RSTN),
        .run         (converter_on_reg),
        .restart     (cold_launch),
        .divider_sel (clock_divider_select_reg),
        .tick        (conv_tick)
    );

    // ****************************************
    // Next values
    // ****************************************
    logic       flag_next;
    logic       lock_next;
    logic [4:0] tick_count_next;
    logic       init_pending_next;
    logic [9:0] result_next;

    assign flag_next         = done || (completion_flag_reg && !IRQ_ACK
                               && !(wr_ctrl && WDATA[asc_pkg::FLAG_BIT]));
    assign lock_next         = rd_low ? 1'b1 : (rd_high ? 1'b0 : read_lock_reg);
    assign result_next       = (done && !read_lock_reg) ? CORE_RESULT
                                                        : conversion_result_reg;
    assign tick_count_next   = launch ? 5'h00
                               : (conv_tick ? tick_count_reg + 5'h01 : tick_count_reg);
    assign init_pending_next = !converter_on_next ? 1'b0
                               : (enable_rise ? !launch
                               : (init_pending_reg && !launch));

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state_reg           <= asc_pkg::ASC_IDLE;
            converter_on_reg    <= 1'b0;
            completion_flag_reg <= 1'b0;
            read_lock_reg       <= 1'b0;
            tick_count_reg      <= 5'h00;
            init_pending_reg    <= 1'b0;
            long_conv_reg       <= 1'b0;
            trig_prev_reg       <= 1'b0;
            conversion_result_reg <= asc_pkg::RESULT_RESET;
        end else begin
            state_reg           <= state_next;
            converter_on_reg    <= converter_on_next;
            completion_flag_reg <= flag_next;
            read_lock_reg       <= lock_next;
            tick_count_reg      <= tick_count_next;
            init_pending_reg    <= init_pending_next;
            trig_prev_reg       <= trig_level;
            conversion_result_reg <= result_next;
            if (launch) begin
                long_conv_reg <= enable_rise || init_pending_reg;
            end
        end
    end

    // ****************************************
    // Software fields
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            auto_trigger_on_reg       <= asc_pkg::CTRL_RESET[asc_pkg::AUTO_TRIGGER_BIT];
            completion_irq_enable_reg <= asc_pkg::CTRL_RESET[asc_pkg::IRQ_ENABLE_BIT];
            clock_divider_select_reg  <= asc_pkg::CTRL_RESET[asc_pkg::DIVIDER_LSB +: 3];
        end else if (wr_ctrl) begin
            auto_trigger_on_reg       <= WDATA[asc_pkg::AUTO_TRIGGER_BIT];
            completion_irq_enable_reg <= WDATA[asc_pkg::IRQ_ENABLE_BIT];
            clock_divider_select_reg  <= WDATA[asc_pkg::DIVIDER_LSB +: 3];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            reference_select_reg <= asc_pkg::INPUT_REF_RESET[asc_pkg::REF_LSB +: 2];
            left_justify_reg     <= asc_pkg::INPUT_REF_RESET[asc_pkg::LEFT_JUSTIFY_BIT];
            channel_select_reg   <= asc_pkg::INPUT_REF_RESET[asc_pkg::CHANNEL_LSB +: 4];
        end else if (wr_input) begin
            reference_select_reg <= WDATA[asc_pkg::REF_LSB +: 2];
            left_justify_reg     <= WDATA[asc_pkg::LEFT_JUSTIFY_BIT];
            channel_select_reg   <= WDATA[asc_pkg::CHANNEL_LSB +: 4];
        end
    end

    // Selection captured at start; software changes wait for the next one
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            active_channel_reg <= 4'h0;
            active_ref_reg     <= 2'h0;
        end else if (launch) begin
            active_channel_reg <= channel_select_reg;
            active_ref_reg     <= reference_select_reg;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [15:0] presented;
    logic [7:0]  ctrl_view;
    logic [7:0]  input_view;
    logic [7:0]  rdata_next;

    assign presented  = left_justify_reg ? {conversion_result_reg, 6'h00}
                                         : {6'h00, conversion_result_reg};
    assign ctrl_view  = {converter_on_reg, busy, auto_trigger_on_reg,
                         completion_flag_reg, completion_irq_enable_reg,
                         clock_divider_select_reg};
    assign input_view = {reference_select_reg, left_justify_reg, 1'b0,
                         channel_select_reg};
    assign rdata_next = rd_low   ? presented[7:0]
                      : rd_high  ? presented[15:8]
                      : rd_ctrl  ? ctrl_view
                      : rd_input ? input_view
                      : 8'h00;

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Idle selection follows software; busy selection is the latched copy
    assign RDATA          = rdata_reg;
    assign IRQ            = completion_flag_reg && completion_irq_enable_reg
                            && GLOBAL_IRQ_EN;
    assign CONVERTER_ON   = converter_on_reg;
    assign CONV_BUSY      = busy;
    assign ADC_CLK_TICK   = conv_tick;
    assign CHANNEL_SEL    = busy ? active_channel_reg : channel_select_reg;
    assign REF_SEL        = busy ? active_ref_reg : reference_select_reg;
    assign TEMP_SENSOR_ON = converter_on_reg
                            && (CHANNEL_SEL == asc_pkg::CHAN_TEMP_SENSOR);

    // ****************************************
    // Checks
    // ****************************************
    logic [4:0] ticks_seen_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ticks_seen_reg <= 5'h00;
        end else if (launch) begin
            ticks_seen_reg <= 5'h00;
        end else if (conv_tick && busy) begin
            ticks_seen_reg <= ticks_seen_reg + 5'h01;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_start_write;
        wr_start && converter_on_next && !busy;
    endsequence

    property p_first_len;
        done && long_conv_reg |-> ticks_seen_reg == 5'h18;
    endproperty
    a_first_len: assert property (p_first_len)
        else $error("first conversion length wrong");

    property p_norm_len;
        done && !long_conv_reg |-> ticks_seen_reg == 5'h0C;
    endproperty
    a_norm_len: assert property (p_norm_len)
        else $error("normal conversion length wrong");

    property p_start_busy;
        s_start_write |=> CONV_BUSY ##1 (CONV_BUSY || !CONVERTER_ON);
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start write did not begin conversion");

    property p_abort;
        wr_ctrl && !WDATA[asc_pkg::CONVERTER_ON_BIT] |=> !CONV_BUSY && !CONVERTER_ON;
    endproperty
    a_abort: assert property (p_abort)
        else $error("disable did not abort");

    property p_flag_done;
        done |=> completion_flag_reg
                 && ($past(read_lock_reg) || conversion_result_reg == $past(CORE_RESULT));
    endproperty
    a_flag_done: assert property (p_flag_done)
        else $error("flag not set on completion");

    property p_ack_clear;
        IRQ_ACK && !done |=> !completion_flag_reg && !IRQ;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("vector did not clear flag");

    property p_lock_hold;
        read_lock_reg && !rd_high |=> $stable(conversion_result_reg);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked result changed");

    property p_sel_stable;
        CONV_BUSY && $past(CONV_BUSY) && !$past(launch) |->
            $stable(CHANNEL_SEL) && $stable(REF_SEL);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("selection changed mid conversion");

    property p_free_run;
        done && free_run && converter_on_next |=> CONV_BUSY && ticks_seen_reg == 5'h00;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free running did not restart");

    property p_irq;
        done && completion_irq_enable_reg && GLOBAL_IRQ_EN && !wr_ctrl |=>
            IRQ || !GLOBAL_IRQ_EN;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request missing");

endmodule // asc_control

// >>> design/asc_pkg.sv
// Purpose: Shared constants of the converter sequencer control block
// Assumes: 8-bit register port, byte addresses as listed
// Notes:   All registers reset to zero

package asc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] RESULT_LOW_OFF   = 8'h78;
    localparam logic [7:0] RESULT_HIGH_OFF  = 8'h79;
    localparam logic [7:0] CTRL_STATUS_OFF  = 8'h7A;
    localparam logic [7:0] INPUT_REF_OFF    = 8'h7C;

    localparam logic [7:0] CTRL_RESET       = 8'h00;
    localparam logic [7:0] INPUT_REF_RESET  = 8'h00;
    localparam logic [9:0] RESULT_RESET     = 10'h000;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CONVERTER_ON_BIT   = 7;
    localparam int START_BIT          = 6;
    localparam int AUTO_TRIGGER_BIT   = 5;
    localparam int FLAG_BIT           = 4;
    localparam int IRQ_ENABLE_BIT     = 3;
    localparam int DIVIDER_LSB        = 0;
    localparam int REF_LSB            = 6;
    localparam int LEFT_JUSTIFY_BIT   = 5;
    localparam int CHANNEL_LSB        = 0;

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [3:0] CHAN_TEMP_SENSOR = 4'h8;
    localparam logic [3:0] CHAN_BANDGAP     = 4'hE;
    localparam logic [3:0] CHAN_GROUND      = 4'hF;
    localparam logic [1:0] REF_PIN          = 2'h0;
    localparam logic [1:0] REF_SUPPLY       = 2'h1;
    localparam logic [1:0] REF_INTERNAL     = 2'h3;
    localparam logic [2:0] TRIG_FREE_RUN    = 3'h0;

    // ****************************************
    // Conversion timing in converter clock cycles
    // ****************************************
    localparam logic [4:0] FIRST_CONV_CYCLES = 5'h19;
    localparam logic [4:0] NORM_CONV_CYCLES  = 5'h0D;

    typedef enum logic [0:0] {
        ASC_IDLE = 1'b0,
        ASC_CONV = 1'b1
    } asc_state_t;

endpackage

// >>> design/asc_prescaler.sv
// Purpose: Divides the system clock into converter clock ticks
// Assumes: Codes 0 and 1 both divide by two
// Notes:   Counter restarts while stopped or on restart

`timescale 1ns/1ps

module asc_prescaler #(
    parameter int CNT_W = 7
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] divider_sel,
    output logic            tick
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] mask;
    logic [2:0]       shift;

    // Division factor two to the power of the code, at least two
    assign shift      = (divider_sel == 3'h0) ? 3'h1 : divider_sel;
    assign mask       = CNT_W'((8'h01 << shift) - 8'h01);
    assign tick       = run && !restart && ((count_reg & mask) == mask);
    assign count_next = (!run || restart || tick) ? '0 : count_reg + 1'b1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule // asc_prescaler

// >>> tb/asc_core_model.sv
// Purpose: Stand-in for the analog mux, reference and converter core
// Assumes: Code follows the latched channel, reference and sensor power
// Notes:   Output wanders every cycle while no conversion runs

`timescale 1ns/1ps

module asc_core_model (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic [3:0] chan,
    input  wire logic [1:0] refs,
    input  wire logic       temp_on,
    output logic      [9:0] result
);
    // ****************************************
    // Conversion code
    // ****************************************
    always_ff @(posedge clk) begin
        if (busy) begin
            result <= {refs, chan, temp_on, 3'h5};
        end else if (^result === 1'bx) begin
            result <= 10'h155;
        end else begin
            result <= ~result;
        end
    end
endmodule // asc_core_model

// >>> tb/tb.sv
// Purpose: Register-level checks of the converter sequencer control
// Assumes: Divider codes 0 and 1 both give two system cycles per tick
// Notes:   Conversion length measured as cycles of busy

`timescale 1ns/1ps

module tb;
    logic       SYS_CLK, RSTN, WR_STB, RD_STB, GLOBAL_IRQ_EN, IRQ_ACK;
    logic [7:0] ADDR, WDATA, RDATA, TRIG_FLAGS;
    logic [2:0] TRIG_SRC_SEL;
    logic [9:0] CORE_RESULT;
    logic [3:0] CHANNEL_SEL;
    logic [1:0] REF_SEL;
    logic       IRQ, CONVERTER_ON, CONV_BUSY, ADC_CLK_TICK, TEMP_SENSOR_ON;
    logic [9:0] r;
    int         error_cnt, checks, div;

    asc_control #(.NUM_TRIG(8)) uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR),
        .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
        .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ_ACK(IRQ_ACK), .IRQ(IRQ),
        .TRIG_SRC_SEL(TRIG_SRC_SEL), .TRIG_FLAGS(TRIG_FLAGS), .CORE_RESULT(CORE_RESULT),
        .CONVERTER_ON(CONVERTER_ON), .CONV_BUSY(CONV_BUSY), .ADC_CLK_TICK(ADC_CLK_TICK),
        .CHANNEL_SEL(CHANNEL_SEL), .REF_SEL(REF_SEL), .TEMP_SENSOR_ON(TEMP_SENSOR_ON));

    asc_core_model core (.clk(SYS_CLK), .busy(CONV_BUSY), .chan(CHANNEL_SEL),
        .refs(REF_SEL), .temp_on(TEMP_SENSOR_ON), .result(CORE_RESULT));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [9:0] exp_res(input logic [3:0] ch, input logic [1:0] rf);
        return {rf, ch, ch == 4'h8, 3'h5};
    endfunction

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge SYS_CLK);
        WR_STB <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge SYS_CLK);
        RD_STB <= 1'b0;
        #1;
        check(RDATA, exp);
    endtask

    // Counts cycles of busy and converter ticks from the launching edge
    task automatic conv(input int exp_len, input int exp_ticks);
        int n;
        int t;
        n = 0;
        t = 0;
        #1;
        while (CONV_BUSY === 1'b1 && n < 5000) begin
            if (ADC_CLK_TICK === 1'b1) begin
                t++;
            end
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        check(12'(n), 12'(exp_len));
        check(12'(t), 12'(exp_ticks));
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        error_cnt++;
        results();
    end

    initial begin
        {RSTN, WR_STB, RD_STB, GLOBAL_IRQ_EN, IRQ_ACK} = 5'h00;
        {ADDR, WDATA, TRIG_FLAGS, TRIG_SRC_SEL} = 27'h0;
        error_cnt = 0;
        checks = 0;
        repeat (8) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        for (int i = 8'h78; i <= 8'h7C; i++) rdc(i[7:0], 8'h00);
        wr(asc_pkg::INPUT_REF_OFF, 8'hFF);
        rdc(asc_pkg::INPUT_REF_OFF, 8'hEF);
        for (int i = 0; i < 16; i++) begin
            wr(asc_pkg::INPUT_REF_OFF, {i[1:0], 2'h0, i[3:0]});
            #1;
            check(CHANNEL_SEL, i[3:0]);
            check(REF_SEL, i[1:0]);
            check(TEMP_SENSOR_ON, 1'b0);
        end
        // Temperature reading, single mode, internal reference
        wr(asc_pkg::INPUT_REF_OFF, 8'hC8);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'hC0);
        conv(50, 25);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h90);
        r = exp_res(4'h8, 2'h3);
        rdc(asc_pkg::RESULT_LOW_OFF, r[7:0]);
        rdc(asc_pkg::RESULT_HIGH_OFF, {6'h00, r[9:8]});
        wr(asc_pkg::INPUT_REF_OFF, 8'hE8);
        rdc(asc_pkg::RESULT_LOW_OFF, {r[1:0], 6'h00});
        rdc(asc_pkg::RESULT_HIGH_OFF, r[9:2]);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'h90);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h80);
        // Selection change mid conversion, then abort
        wr(asc_pkg::CTRL_STATUS_OFF, 8'hC7);
        wr(asc_pkg::INPUT_REF_OFF, 8'h41);
        #1;
        check({CHANNEL_SEL, REF_SEL, TEMP_SENSOR_ON}, 7'h47);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'h87);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'hC7);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'h07);
        #1;
        check({CONV_BUSY, CONVERTER_ON, CHANNEL_SEL}, 6'h01);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h07);
        // Re-enable: long first conversion, then every divider code
        wr(asc_pkg::CTRL_STATUS_OFF, 8'hC0);
        conv(50, 25);
        for (int c = 0; c < 8; c++) begin
            div = (c < 2) ? 2 : (1 << c);
            wr(asc_pkg::CTRL_STATUS_OFF, 8'hD0 | c[7:0]);
            conv(13 * div, 13);
        end
        r = exp_res(4'h1, 2'h1);
        rdc(asc_pkg::RESULT_LOW_OFF, r[7:0]);
        wr(asc_pkg::INPUT_REF_OFF, 8'hC8);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'hD0);
        conv(26, 13);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h90);
        rdc(asc_pkg::RESULT_HIGH_OFF, {6'h00, r[9:8]});
        rdc(asc_pkg::RESULT_LOW_OFF, r[7:0]);
        rdc(asc_pkg::RESULT_HIGH_OFF, {6'h00, r[9:8]});
        wr(asc_pkg::CTRL_STATUS_OFF, 8'h88);
        #1;
        check(CONV_BUSY, 1'b0);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h98);
        // Interrupt request gating and vector clear
        @(posedge SYS_CLK);
        GLOBAL_IRQ_EN <= 1'b1;
        @(posedge SYS_CLK);
        #1;
        check(IRQ, 1'b1);
        @(posedge SYS_CLK);
        GLOBAL_IRQ_EN <= 1'b0;
        #1;
        check(IRQ, 1'b0);
        @(posedge SYS_CLK);
        GLOBAL_IRQ_EN <= 1'b1;
        IRQ_ACK <= 1'b1;
        @(posedge SYS_CLK);
        IRQ_ACK <= 1'b0;
        #1;
        check(IRQ, 1'b0);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h88);
        // Auto trigger with interrupt enabled, then free running
        @(posedge SYS_CLK);
        TRIG_SRC_SEL <= 3'h3;
        wr(asc_pkg::CTRL_STATUS_OFF, 8'hA8);
        TRIG_FLAGS <= 8'h08;
        @(posedge SYS_CLK);
        conv(26, 13);
        check(IRQ, 1'b1);
        @(posedge SYS_CLK);
        TRIG_SRC_SEL <= asc_pkg::TRIG_FREE_RUN;
        repeat (4) @(posedge SYS_CLK);
        #1;
        check(CONV_BUSY, 1'b0);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'hE0);
        repeat (40) @(posedge SYS_CLK);
        #1;
        check(CONV_BUSY, 1'b1);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'hF0);
        wr(asc_pkg::CTRL_STATUS_OFF, 8'h90);
        repeat (30) @(posedge SYS_CLK);
        #1;
        check(CONV_BUSY, 1'b0);
        rdc(asc_pkg::CTRL_STATUS_OFF, 8'h90);
        results();
    end
endmodule // tb
